// ### common/pacb_defines.vh
// constants for the post-acquisition calc block
`ifndef PACB_DEFINES_VH
`define PACB_DEFINES_VH
// register offsets (word index on the plain port)
`define PACB_A_FEED1 4'h0
`define PACB_A_FEED2 4'h1
`define PACB_A_OFFSET 4'h2
`define PACB_A_OFS_EN 4'h3
`define PACB_A_CLR_AUTO 4'h4
`define PACB_A_CLR_IMM 4'h5
`define PACB_A_LIM_EN 4'h6
`define PACB_A_LOWER 4'h7
`define PACB_A_UPPER 4'h8
`define PACB_A_FCOUNT 4'h9
`define PACB_A_FAIL 4'hA
`define PACB_A_RESULT 4'hB
`define PACB_A_ERROR 4'hC
// measurement types
`define PACB_T_PEAK 2'h0
`define PACB_T_PEAK_TO_AVERAGE_TYPE 2'h1
`define PACB_T_AVERAGE_TYPE 2'h2
`define PACB_T_MIN 2'h3
// feed write fields
`define PACB_F_TYPE_LO 0
`define PACB_F_TYPE_HI 1
`define PACB_F_GATE_LO 2
`define PACB_F_GATE_HI 3
`define PACB_F_GATE_GIVEN 4
`define PACB_F_EMPTY 5
// trigger source codes
`define PACB_TS_INT 2'h0
`define PACB_TS_EXT 2'h1
// auto clear modes
`define PACB_AC_OFF 2'h0
`define PACB_AC_ON 2'h1
`define PACB_AC_ONCE 2'h2
// offset range in milli-dB
`define PACB_OFS_MAX 32'sd100000
`define PACB_OFS_MIN -32'sd100000
// error code: settings conflict
`define PACB_ERR_CONFLICT 16'hFF23
`define PACB_ZERO16 16'h0000
`define PACB_ONE16 16'h0001
`endif

// ### rtl/pacb_calc.v
// four post-acquisition calc instances with register port
//
// Our own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "pacb_defines.vh"
module pacb_calc #(
  parameter DW = 32, // result width, signed milli-dB
  parameter CW = 16 // failure counter width
) (
  input wire clk, // 40 MHz clock
  input wire rst, // synchronous reset, active high
  input wire [1:0] inst_sel, // instance suffix minus one
  input wire [3:0] addr, // register index
  input wire [DW-1:0] wr_data, // write data
  input wire wr_en, // write strobe
  input wire rd_en, // read strobe
  output reg [DW-1:0] rd_data, // read data, cycle after strobe
  input wire meas_start, // measurement start pulse
  input wire [DW-1:0] math_result, // math stage output
  input wire math_valid, // math result strobe
  input wire [3:0] trig_source, // trigger source, 2 bits per feed
  input wire detector_average, // detector function is average-only
  input wire measurement_rate_fast, // measurement rate is fast
  output reg [4*DW-1:0] final_result, // result plus offset, per inst
  output reg [3:0] result_valid, // result strobe per instance
  output reg [3:0] fail_flag, // counter non-zero per instance
  output reg error_pulse // conflict error raised
);
  // ***************************************************
  // per-instance state
  // ***************************************************
  reg [1:0] feed_type [0:7]; // index inst*2+feed
  reg [1:0] feed_gate [0:7]; // gate minus one
  reg signed [DW-1:0] offset [0:3]; // offset, milli-dB
  reg ofs_en [0:3]; // offset enable
  reg [1:0] clr_mode [0:3]; // auto clear mode
  reg once_done [0:3]; // once mode consumed
  reg lim_en [0:3]; // limit check enable
  reg signed [DW-1:0] lower [0:3]; // lower limit
  reg signed [DW-1:0] upper [0:3]; // upper limit
  reg [CW-1:0] fcount [0:3]; // failure_counter
  reg [15:0] last_err; // last error code
  // each process owns its own loop index, so no index has two drivers
  integer i; // loop index, limit compare
  integer j; // loop index, configuration
  integer k; // loop index, counter next state
  integer n; // loop index, counter registers
  integer m; // loop index, result path
  // ***************************************************
  // write decode helpers
  // ***************************************************
  wire wr_f1 = wr_en && (addr == `PACB_A_FEED1); // feed 1 write
  wire wr_f2 = wr_en && (addr == `PACB_A_FEED2); // feed 2 write
  wire wr_feed = wr_f1 || wr_f2;
  wire [2:0] fidx = {inst_sel, wr_f2}; // addressed feed
  wire [2:0] oidx = {inst_sel, ~wr_f2}; // coupled feed
  wire [1:0] new_type = wr_data[`PACB_F_TYPE_HI:`PACB_F_TYPE_LO];
  wire gate_given = wr_data[`PACB_F_GATE_GIVEN];
  wire feed_empty = wr_data[`PACB_F_EMPTY];
  wire [1:0] feed_ts = wr_f2 ? trig_source[3:2] : trig_source[1:0];
  // gate needs internal or external trigger
  wire gate_bad = gate_given && (feed_ts != `PACB_TS_INT) &&
    (feed_ts != `PACB_TS_EXT);
  // peak kinds need a peak detector
  wire type_bad = detector_average && ((new_type == `PACB_T_PEAK) ||
    (new_type == `PACB_T_PEAK_TO_AVERAGE_TYPE));
  wire feed_err = wr_feed && !feed_empty && (gate_bad || type_bad);
  wire signed [DW-1:0] sdata = wr_data; // signed view of write
  wire ofs_range = (sdata <= `PACB_OFS_MAX) &&
    (sdata >= `PACB_OFS_MIN);
  wire wr_ofs = wr_en && (addr == `PACB_A_OFFSET);
  wire wr_oen = wr_en && (addr == `PACB_A_OFS_EN);
  // offset write in fast rate, or out of range, is refused
  wire ofs_err = wr_ofs && (measurement_rate_fast || !ofs_range);
  wire oen_err = wr_oen && wr_data[0] && measurement_rate_fast;
  wire wr_lim = wr_en && (addr == `PACB_A_LIM_EN);
  // limit check also refused in fast rate
  wire lim_err = wr_lim && wr_data[0] && measurement_rate_fast;
  wire any_err = feed_err || ofs_err || oen_err || lim_err;
  // ***************************************************
  // limit comparison on the final, offset result
  // ***************************************************
  reg signed [DW-1:0] adj [0:3]; // offset-adjusted result
  reg [3:0] outside; // strictly outside limits
  always @*
  begin
    for (i = 0; i < 4; i = i + 1)
    begin
      // offset only ever follows the math stage
      adj[i] = ofs_en[i] ? $signed(math_result) + offset[i]
                         : $signed(math_result);
      // equal to a limit is a pass
      outside[i] = (adj[i] < lower[i]) || (adj[i] > upper[i]);
    end
  end
  // ***************************************************
  // configuration and error register
  // ***************************************************
  always @(posedge clk)
  begin
    if (rst)
    begin
      // every feed of every instance back to average power
      for (j = 0; j < 8; j = j + 1)
      begin
        feed_type[j] <= `PACB_T_AVERAGE_TYPE;
        feed_gate[j] <= 2'h0; // gate 1
      end
      // offset, enables and limits of all four instances
      for (j = 0; j < 4; j = j + 1)
      begin
        offset[j] <= {DW{1'b0}}; // 0 dB
        ofs_en[j] <= 1'b0;
        lim_en[j] <= 1'b0;
        lower[j] <= {DW{1'b0}}; // limits start at zero
        upper[j] <= {DW{1'b0}}; // limits start at zero
      end
      last_err <= `PACB_ZERO16;
      error_pulse <= 1'b0;
    end
    else
    begin
      error_pulse <= any_err;
      if (any_err)
        last_err <= `PACB_ERR_CONFLICT;
      // suffix steers the write to one instance
      if (wr_feed && !feed_empty && !feed_err)
      begin
        feed_type[fidx] <= new_type;
        // peak-to-average on one feed also sets the coupled feed
        if (new_type == `PACB_T_PEAK_TO_AVERAGE_TYPE)
          feed_type[oidx] <= `PACB_T_PEAK_TO_AVERAGE_TYPE;
        if (gate_given)
          feed_gate[fidx] <= wr_data[`PACB_F_GATE_HI:`PACB_F_GATE_LO];
        // no gate given: previous gate stands
      end
      if (wr_ofs && !ofs_err)
      begin
        offset[inst_sel] <= sdata;
        ofs_en[inst_sel] <= 1'b1;
      end
      if (wr_oen && !oen_err)
        ofs_en[inst_sel] <= wr_data[0];
      if (wr_lim && !lim_err)
        lim_en[inst_sel] <= wr_data[0];
      if (wr_en && (addr == `PACB_A_LOWER))
        lower[inst_sel] <= sdata;
      if (wr_en && (addr == `PACB_A_UPPER))
        upper[inst_sel] <= sdata;
      if (rd_en && (addr == `PACB_A_ERROR))
        last_err <= any_err ? `PACB_ERR_CONFLICT : `PACB_ZERO16;
    end
  end
  // ***************************************************
  // failure counters and auto clear
  // ***************************************************
  // a failing result in the same cycle as a clear still counts:
  // the clear is applied first, then the increment
  // the next counter value is worked out combinationally, so the
  // registers below only ever take non-blocking updates
  reg [CW-1:0] next_fcount [0:3]; // counter after this cycle
  reg [3:0] next_fail_flag; // flag after this cycle
  reg [3:0] clr_now; // clear applied this cycle
  // ***************************************************
  // counter next state
  // ***************************************************
  always @*
  begin
    clr_now = 4'h0;
    next_fail_flag = 4'h0;
    for (k = 0; k < 4; k = k + 1)
    begin
      // immediate clear ignores auto mode
      if (wr_en && (addr == `PACB_A_CLR_IMM) && (inst_sel == k))
        clr_now[k] = 1'b1;
      // writing auto-clear on zeroes the counter too
      if (wr_en && (addr == `PACB_A_CLR_AUTO) && (inst_sel == k) &&
          (wr_data[1:0] == `PACB_AC_ON))
        clr_now[k] = 1'b1;
      // a start is shared by all four instances
      if (meas_start)
      begin
        case (clr_mode[k])
          `PACB_AC_ON: clr_now[k] = 1'b1;
          `PACB_AC_ONCE:
            if (!once_done[k])
              clr_now[k] = 1'b1;
          default: clr_now[k] = clr_now[k]; // off accumulates
        endcase
      end
      // start from zero when any clear applies
      next_fcount[k] = clr_now[k] ? {CW{1'b0}} : fcount[k];
      // wraps to zero past full count, no saturation
      if (math_valid && lim_en[k] && outside[k])
        next_fcount[k] = next_fcount[k] +
          {{(CW-1){1'b0}}, 1'b1};
      // flag follows the counter of the same cycle
      next_fail_flag[k] = (next_fcount[k] != {CW{1'b0}});
    end
  end
  // ***************************************************
  // counter and auto clear registers
  // ***************************************************
  always @(posedge clk)
  begin
    if (rst)
    begin
      for (n = 0; n < 4; n = n + 1)
      begin
        fcount[n] <= {CW{1'b0}}; // counter empty
        clr_mode[n] <= `PACB_AC_ON;
        once_done[n] <= 1'b0; // once mode armed
      end
      fail_flag <= 4'h0;
    end
    else
    begin
      fail_flag <= next_fail_flag;
      for (n = 0; n < 4; n = n + 1)
      begin
        fcount[n] <= next_fcount[n];
        // rewriting the mode re-arms once mode
        if (wr_en && (addr == `PACB_A_CLR_AUTO) && (inst_sel == n))
        begin
          clr_mode[n] <= wr_data[1:0];
          once_done[n] <= 1'b0;
        end
        // the first start after arming uses up once mode
        else if (meas_start && (clr_mode[n] == `PACB_AC_ONCE))
          once_done[n] <= 1'b1;
      end
    end
  end
  // ***************************************************
  // result path
  // ***************************************************
  always @(posedge clk)
  begin
    if (rst)
    begin
      final_result <= {4*DW{1'b0}};
      result_valid <= 4'h0;
    end
    else
    begin
      // all four instances see the same math result
      for (m = 0; m < 4; m = m + 1)
        final_result[m*DW +: DW] <= adj[m];
      result_valid <= {4{math_valid}};
    end
  end
  // ***************************************************
  // read port
  // ***************************************************
  wire [2:0] r1 = {inst_sel, 1'b0}; // feed 1 index
  wire [2:0] r2 = {inst_sel, 1'b1}; // feed 2 index
  reg [DW-1:0] next_rd_data;
  always @*
  begin
    next_rd_data = {DW{1'b0}};
    case (addr)
      `PACB_A_FEED1: next_rd_data = {{(DW-4){1'b0}}, feed_gate[r1],
                                     feed_type[r1]};
      `PACB_A_FEED2: next_rd_data = {{(DW-4){1'b0}}, feed_gate[r2],
                                     feed_type[r2]};
      `PACB_A_OFFSET: next_rd_data = offset[inst_sel];
      `PACB_A_OFS_EN: next_rd_data = {{(DW-1){1'b0}}, ofs_en[inst_sel]};
      // once reads 1 until a start, then 0
      `PACB_A_CLR_AUTO: next_rd_data = {{(DW-1){1'b0}},
        (clr_mode[inst_sel] == `PACB_AC_ON) ||
        ((clr_mode[inst_sel] == `PACB_AC_ONCE) &&
         !once_done[inst_sel])};
      `PACB_A_LIM_EN: next_rd_data = {{(DW-1){1'b0}}, lim_en[inst_sel]};
      `PACB_A_LOWER: next_rd_data = lower[inst_sel];
      `PACB_A_UPPER: next_rd_data = upper[inst_sel];
      `PACB_A_FCOUNT: next_rd_data = {{(DW-CW){1'b0}}, fcount[inst_sel]};
      `PACB_A_FAIL: next_rd_data = {{(DW-1){1'b0}},
        fail_flag[inst_sel]};
      `PACB_A_RESULT: next_rd_data = final_result[inst_sel*DW +: DW];
      `PACB_A_ERROR: next_rd_data = {{(DW-16){1'b0}}, last_err};
      default: next_rd_data = {DW{1'b0}}; // unmapped reads zero
    endcase
  end
  // read data stands only in the cycle after the strobe
  always @(posedge clk)
  begin
    if (rst)
      rd_data <= {DW{1'b0}};
    else if (rd_en)
      rd_data <= next_rd_data;
    else
      rd_data <= {DW{1'b0}};
  end
endmodule // pacb_calc

// ### dv/pacb_calc_properties.sv
// port checker for the calc block
`timescale 1ns/1ps
`include "pacb_defines.vh"
module pacb_chk (
  input wire clk, // clock
  input wire rst, // sync reset
  input wire [1:0] inst_sel, // instance
  input wire [3:0] addr, // index
  input wire [31:0] wr_data, // write data
  input wire wr_en, // write strobe
  input wire meas_start, // start pulse
  input wire math_valid, // math strobe
  input wire [3:0] trig_source, // trigger codes
  input wire detector_average, // average-only
  input wire measurement_rate_fast, // fast rate
  input wire [3:0] result_valid, // result strobes
  input wire [3:0] fail_flag, // fail flags
  input wire error_pulse // conflict pulse
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // feed write that is not the empty string
  wire fw = wr_en && addr <= `PACB_A_FEED2 && !wr_data[5];
  // trigger code of the addressed feed is neither 0 nor 1
  wire badt = addr[0] ? trig_source[3] : trig_source[1];
  a_gate_conflict: assert property (
    fw && wr_data[4] && badt |=> error_pulse)
    else $error("gate accepted with bad trigger");
  a_det_conflict: assert property (
    fw && !wr_data[1] && detector_average |=> error_pulse)
    else $error("peak type accepted with average detector");
  a_empty_quiet: assert property (
    wr_en && addr <= `PACB_A_FEED2 && wr_data[5] |=> !error_pulse)
    else $error("empty feed raised error");
  a_fast_enable: assert property (
    wr_en && addr == `PACB_A_OFS_EN && wr_data[0] &&
    measurement_rate_fast |=> error_pulse)
    else $error("enable accepted at fast rate");
  a_fast_offset: assert property (
    wr_en && addr == `PACB_A_OFFSET && measurement_rate_fast
    |=> error_pulse)
    else $error("offset accepted at fast rate");
  a_valid_follows: assert property (
    math_valid |=> result_valid == 4'hF)
    else $error("result strobe missing");
  a_imm_clear: assert property (
    wr_en && addr == `PACB_A_CLR_IMM && !math_valid
    |=> !fail_flag[$past(inst_sel)])
    else $error("clear left flag set");
  a_flag_hold: assert property (
    !math_valid && !wr_en && !meas_start |=> $stable(fail_flag))
    else $error("flag moved without cause");
  a_reset_flag: assert property (
    disable iff (1'b0) rst |=> fail_flag == 4'h0)
    else $error("flag set after reset");
  cover property (error_pulse);
  cover property (math_valid && fail_flag[3]);
  cover property (meas_start && fail_flag[3]);
endmodule // pacb_chk
bind pacb_calc pacb_chk u_chk (.*);

// ### dv/pacb_host.sv
// host model driving the register port
`timescale 1ns/1ps
module pacb_host (
  input wire clk, // clock
  input wire [31:0] rd_data, // read data
  output reg [1:0] inst_sel, // instance
  output reg [3:0] addr, // index
  output reg [31:0] wr_data, // write data
  output reg wr_en, // write strobe
  output reg rd_en // read strobe
);
  initial
  begin
    inst_sel = 2'h0;
    addr = 4'h0;
    wr_data = 32'h0;
    wr_en = 1'b0;
    rd_en = 1'b0;
  end
  // write strobe, then an idle edge so calls never collide
  task wr(input [1:0] n, input [3:0] a, input [31:0] v);
    inst_sel <= n;
    addr <= a;
    wr_data <= v;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    @(posedge clk);
  endtask
  // data stands only in the cycle after the strobe
  task rd(input [1:0] n, input [3:0] a, output [31:0] v);
    inst_sel <= n;
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    // taken at the next rising edge, before the slave clears it
    @(posedge clk);
    v = rd_data;
  endtask
endmodule // pacb_host

// ### dv/pacb_calc_tb.sv
// self-checking bench for the calc block
`timescale 1ns/1ps
`include "pacb_defines.vh"
module pacb_calc_tb;
  logic clk = 0, rst = 1, meas_start = 0, math_valid = 0;
  logic detector_average = 0, measurement_rate_fast = 0;
  logic wr_en, rd_en, error_pulse;
  logic [1:0] inst_sel;
  logic [3:0] addr, result_valid, fail_flag;
  logic [3:0] trig_source = 4'h0;
  logic [31:0] wr_data, rd_data, d;
  logic [31:0] math_result = 32'h0;
  logic [127:0] final_result;
  integer num_errors = 0, n_checks = 0, n_err = 0, e_exp = 0;
  integer seed = 32'hbb71, cnt = 0, ac = 1, armed = 0, le = 0, i, r;
  pacb_host host (.clk(clk), .rd_data(rd_data), .inst_sel(inst_sel),
    .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en));
  pacb_calc uut (.clk(clk), .rst(rst), .inst_sel(inst_sel), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .meas_start(meas_start), .math_result(math_result),
    .math_valid(math_valid), .trig_source(trig_source),
    .detector_average(detector_average),
    .measurement_rate_fast(measurement_rate_fast),
    .final_result(final_result), .result_valid(result_valid),
    .fail_flag(fail_flag), .error_pulse(error_pulse));
  initial
    forever #12.5 clk = ~clk;
  // count refusals as the block reports them
  always @(posedge clk)
    if (error_pulse === 1'b1)
      n_err <= n_err + 1;
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
      $display("FAIL %0t got %h exp %h", $time, g, e);
    if (g !== e)
      num_errors++;
  endtask
  task rc(input [1:0] n, input [3:0] a, input [31:0] e);
    host.rd(n, a, d);
    chk(d, e);
  endtask
  // one math result; model counts failures of instance 3
  task mv(input integer v);
    math_result <= v;
    math_valid <= 1'b1;
    @(posedge clk);
    math_valid <= 1'b0;
    if (le && (v < 0 || v > 10))
      cnt = (cnt + 1) % 65536;
    @(posedge clk);
    chk(fail_flag, {cnt != 0, 3'h0});
    chk(result_valid, 4'hF);
  endtask
  // measurement start with the model's auto-clear
  task ms;
    meas_start <= 1'b1;
    @(posedge clk);
    meas_start <= 1'b0;
    if (ac == 1 || (ac == 2 && armed))
      cnt = 0;
    armed = 0;
    @(posedge clk);
  endtask
  task setac(input integer m);
    host.wr(2'h3, `PACB_A_CLR_AUTO, m);
    if (m == 1)
      cnt = 0;
    armed = (m == 2);
    ac = m;
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    repeat (100000) @(posedge clk);
    num_errors++;
    wrap_up;
  end
  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (i = 0; i < 4; i++)
    begin
      host.rd(i, `PACB_A_FEED1, d);
      chk(d[1:0], 2);
      rc(i, `PACB_A_CLR_AUTO, 1);
      rc(i, `PACB_A_OFS_EN, 0);
      rc(i, `PACB_A_LIM_EN, 0);
      rc(i, `PACB_A_FAIL, 0);
      rc(i, `PACB_A_OFFSET, 0);
    end
    host.wr(2'h1, `PACB_A_FEED1, 32'h01);
    host.rd(2'h1, `PACB_A_FEED2, d);
    chk(d[1:0], 1);
    host.wr(2'h1, `PACB_A_FEED1, 32'h1B);
    host.wr(2'h1, `PACB_A_FEED1, 32'h02);
    rc(2'h1, `PACB_A_FEED1, 32'h0A);
    host.wr(2'h1, `PACB_A_FEED1, 32'h20);
    rc(2'h1, `PACB_A_FEED1, 32'h0A);
    trig_source <= 4'h2;
    host.wr(2'h1, `PACB_A_FEED1, 32'h13);
    rc(2'h1, `PACB_A_FEED1, 32'h0A);
    trig_source <= 4'h0;
    detector_average <= 1'b1;
    host.wr(2'h1, `PACB_A_FEED1, 32'h00);
    rc(2'h1, `PACB_A_FEED1, 32'h0A);
    detector_average <= 1'b0;
    host.wr(2'h2, `PACB_A_OFFSET, 32'h4E20);
    rc(2'h2, `PACB_A_OFS_EN, 1);
    r = $random(seed) % 1000;
    mv(r);
    chk(final_result[95:64], r + 20000);
    chk(final_result[31:0], r);
    host.wr(2'h2, `PACB_A_OFFSET, `PACB_OFS_MAX + 1);
    rc(2'h2, `PACB_A_OFFSET, 32'h4E20);
    host.wr(2'h2, `PACB_A_OFFSET, `PACB_OFS_MIN);
    rc(2'h2, `PACB_A_OFFSET, `PACB_OFS_MIN);
    measurement_rate_fast <= 1'b1;
    host.wr(2'h0, `PACB_A_OFS_EN, 32'h1);
    host.wr(2'h0, `PACB_A_OFFSET, 32'h5);
    rc(2'h0, `PACB_A_OFS_EN, 0);
    measurement_rate_fast <= 1'b0;
    e_exp = 5;
    chk(n_err, e_exp);
    host.wr(2'h3, `PACB_A_UPPER, 32'hA);
    host.wr(2'h3, `PACB_A_LIM_EN, 32'h1);
    le = 1;
    setac(0);
    mv(0);
    mv(10);
    mv(-1);
    mv(11);
    for (i = 0; i < 10; i++)
      mv($random(seed) % 16);
    ms;
    rc(2'h3, `PACB_A_FCOUNT, cnt);
    setac(1);
    mv(11);
    ms;
    rc(2'h3, `PACB_A_FCOUNT, cnt);
    setac(2);
    rc(2'h3, `PACB_A_CLR_AUTO, 1);
    mv(-1);
    ms;
    rc(2'h3, `PACB_A_CLR_AUTO, 0);
    mv(-1);
    ms;
    rc(2'h3, `PACB_A_FCOUNT, cnt);
    host.wr(2'h3, `PACB_A_CLR_IMM, 32'h1);
    cnt = 0;
    rc(2'h3, `PACB_A_FAIL, 0);
    setac(0);
    math_result <= 32'h32;
    math_valid <= 1'b1;
    repeat (65535) @(posedge clk);
    math_valid <= 1'b0;
    cnt = 65535;
    rc(2'h3, `PACB_A_FCOUNT, cnt);
    mv(50);
    rc(2'h3, `PACB_A_FCOUNT, 0);
    wrap_up;
  end
endmodule // pacb_calc_tb
